// ==== dcsp_device.sv ====
// Device end: serial register port with identity registers
// Assumes link pins asynchronous to CORE_CLK_I, link clock
// at most an eighth of the core clock
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module dcsp_device
    import dcsp_pkg::*;
#(
    parameter logic [7:0]  CHIP_TYPE  = 8'h11, // Arbitrary value
    parameter logic [15:0] PRODUCT_ID = 16'h5A3C, // Arbitrary value
    parameter logic [3:0]  GRADE      = 4'h1, // Arbitrary value
    parameter logic [3:0]  REVISION   = 4'h1 // Arbitrary value
) (
    input  wire logic       CORE_CLK_I,
    input  wire logic       RESET_I,
    dcsp_if.dev             LINK,
    output logic      [7:0] CONFIG_O,
    output logic            SOFT_RESET_O,
    output logic            WRITE_PULSE_O
);
    // ==========================================
    // Pin synchronisers
    logic [1:0]  cs_s;
    logic [2:0]  sck_s;
    logic [1:0]  din_s;
    logic        cs_hi;
    logic        rise;
    logic        fall;
    logic        din;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            cs_s  <= 2'h3;
            sck_s <= 3'h0;
            din_s <= 2'h3;
        end else begin
            cs_s  <= {cs_s[0], LINK.cs_n};
            sck_s <= {sck_s[1:0], LINK.sclk};
            din_s <= {din_s[0], LINK.sdio_lvl};
        end
    end

    assign cs_hi = cs_s[1];
    assign rise  = ~cs_hi & sck_s[1] & ~sck_s[2];
    assign fall  = ~cs_hi & ~sck_s[1] & sck_s[2];
    assign din   = din_s[1];

    // ==========================================
    // Settings
    logic        set_rst;
    logic        set_lsb;
    logic        set_inc;
    logic        set_4w;
    logic [7:0]  cfg_byte;

    assign cfg_byte = {set_rst, set_lsb, set_inc, set_4w,
                       set_4w, set_inc, set_lsb, set_rst};

    // ==========================================
    // Frame state
    dcsp_phase_t phase;
    logic [4:0]  cnt;
    logic [15:0] sr;
    logic [15:0] next_sr;
    logic [7:0]  next_byte;
    logic        instr_done;
    logic        byte_done;
    logic        rd;
    logic [14:0] addr;
    logic [14:0] next_addr;
    logic [7:0]  tx;
    logic        drive;
    logic [3:0]  nib;
    logic        cfg_wr;

    always_comb begin
        next_sr = set_lsb ? {din, sr[15:1]}
                          : {sr[14:0], din};
        next_byte = set_lsb ? next_sr[15:8] : next_sr[7:0];
        instr_done = rise && phase == PH_INSTR &&
                     cnt == 5'(INSTR_BITS - 1);
        byte_done = rise && phase == PH_DATA &&
                    cnt == 5'(BYTE_BITS - 1);
        next_addr = set_inc ? addr + 15'h0001
                            : addr - 15'h0001;
        nib = set_lsb ? {next_byte[0], next_byte[1],
                         next_byte[2], next_byte[3]}
                      : next_byte[7:4];
        cfg_wr = byte_done && !rd && addr == OFF_CFG;
    end

    function automatic logic [7:0] reg_val(input logic [14:0] a,
                                           input logic [7:0] c);
        case (a)
            OFF_CFG:    reg_val = c;
            OFF_CHIP:   reg_val = CHIP_TYPE;
            OFF_PID_LO: reg_val = PRODUCT_ID[7:0];
            OFF_PID_HI: reg_val = PRODUCT_ID[15:8];
            OFF_GRADE:  reg_val = {GRADE, REVISION};
            default:    reg_val = 8'h00;
        endcase
    endfunction

    // ==========================================
    // Bit counting and phase
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || cs_hi) begin
            phase <= PH_INSTR;
            cnt   <= 5'h00;
        end else if (rise) begin
            unique case (phase)
                PH_INSTR: begin
                    if (instr_done) begin
                        phase <= PH_DATA;
                        cnt   <= 5'h00;
                    end else begin
                        cnt <= cnt + 5'h01;
                    end
                end
                PH_DATA: begin
                    cnt <= byte_done ? 5'h00 : cnt + 5'h01;
                end
            endcase
        end
    end

    // ==========================================
    // Shift register, instruction decode, address
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            sr   <= 16'h0000;
            rd   <= 1'b0;
            addr <= 15'h0000;
        end else if (rise) begin
            sr <= next_sr;
            if (instr_done) begin
                rd   <= next_sr[15];
                addr <= next_sr[14:0];
            end else if (byte_done) begin
                addr <= next_addr;
            end
        end
    end

    // ==========================================
    // Configuration register writes
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            {set_rst, set_lsb, set_inc, set_4w} <= CFG_RESET;
        end else if (cfg_wr) begin
            if (nib[3]) begin
                {set_rst, set_lsb, set_inc, set_4w} <=
                    CFG_RESET | 4'h8;
            end else begin
                {set_rst, set_lsb, set_inc, set_4w} <= nib;
            end
        end
    end

    // ==========================================
    // Read data serialiser
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            tx <= 8'h00;
        end else if (instr_done && next_sr[15]) begin
            tx <= reg_val(next_sr[14:0], cfg_byte);
        end else if (byte_done && rd) begin
            tx <= reg_val(next_addr, cfg_byte);
        end else if (fall && phase == PH_DATA && rd) begin
            tx <= set_lsb ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
        end
    end

    // ==========================================
    // Pin drivers
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || cs_hi) begin
            drive <= 1'b0;
        end else if (fall && phase == PH_DATA && rd) begin
            drive <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            LINK.dev_sdio_o <= 1'b0;
            LINK.dev_sdo_o  <= 1'b0;
        end else if (fall && phase == PH_DATA && rd) begin
            LINK.dev_sdio_o <= set_lsb ? tx[0] : tx[7];
            LINK.dev_sdo_o  <= set_lsb ? tx[0] : tx[7];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || cs_hi) begin
            LINK.dev_sdio_oe <= 1'b0;
            LINK.dev_sdo_oe  <= 1'b0;
        end else begin
            LINK.dev_sdio_oe <= (drive || (fall && rd &&
                phase == PH_DATA)) && !set_4w;
            LINK.dev_sdo_oe  <= (drive || (fall && rd &&
                phase == PH_DATA)) && set_4w;
        end
    end

    // ==========================================
    // User-side status
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            CONFIG_O      <= 8'h00;
            SOFT_RESET_O  <= 1'b0;
            WRITE_PULSE_O <= 1'b0;
        end else begin
            CONFIG_O      <= cfg_byte;
            SOFT_RESET_O  <= set_rst;
            WRITE_PULSE_O <= byte_done && !rd;
        end
    end

endmodule // dcsp_device

// ==== dcsp_pkg.sv ====
// Constants shared by both ends of the configuration serial port
// Assumes a 50 MHz core clock on both ends
package dcsp_pkg;
    // ==========================================
    // Serial framing
    localparam int INSTR_BITS = 16;
    localparam int BYTE_BITS  = 8;
    // ==========================================
    // Device register offsets
    localparam logic [14:0] OFF_CFG    = 15'h0000;
    localparam logic [14:0] OFF_CHIP   = 15'h0003;
    localparam logic [14:0] OFF_PID_LO = 15'h0004;
    localparam logic [14:0] OFF_PID_HI = 15'h0005;
    localparam logic [14:0] OFF_GRADE  = 15'h0006;
    // Settings nibble {soft reset, low first, incr, four wire}
    localparam logic [3:0]  CFG_RESET    = 4'h0;
    localparam logic [7:0]  SOFT_RST_PAT = 8'hBD;
    localparam logic [7:0]  CFG_RELEASE  = 8'h3C;
    // ==========================================
    // Host register map, byte addresses
    localparam logic [4:0] HREG_ADDR   = 5'h00;
    localparam logic [4:0] HREG_CTRL   = 5'h04;
    localparam logic [4:0] HREG_WDATA  = 5'h08;
    localparam logic [4:0] HREG_RDATA  = 5'h0C;
    localparam logic [4:0] HREG_STATUS = 5'h10;
    localparam int CTRL_RW  = 0;
    localparam int CTRL_CNT = 2;
    localparam int CTRL_LSB = 4;
    localparam int CTRL_3W  = 5;
    localparam int CTRL_GO  = 8;
    // ==========================================
    // Link timing
    localparam int CLK_NS        = 20;
    localparam int LINK_HALF_NS  = 80;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
    // ==========================================
    // State encodings
    typedef enum logic [0:0] {
        PH_INSTR = 1'b0,
        PH_DATA  = 1'b1
    } dcsp_phase_t;
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_LEAD  = 3'b001,
        H_LOW   = 3'b010,
        H_HIGH  = 3'b011,
        H_TRAIL = 3'b100,
        H_GAP   = 3'b101
    } dcsp_hstate_t;
endpackage

// ==== dcsp_if.sv ====
// Wires of the configuration serial link
// Assumes an idle-high pull on both data wires
`timescale 1ns/1ps
interface dcsp_if;
    logic cs_n;
    logic sclk;
    logic host_sdio_o;
    logic host_sdio_oe;
    logic dev_sdio_o;
    logic dev_sdio_oe;
    logic dev_sdo_o;
    logic dev_sdo_oe;
    logic sdio_lvl;
    logic sdo_lvl;
    // ==========================================
    // Wire resolution, pulled high when undriven
    assign sdio_lvl = dev_sdio_oe  ? dev_sdio_o  :
                      host_sdio_oe ? host_sdio_o : 1'b1;
    assign sdo_lvl  = dev_sdo_oe ? dev_sdo_o : 1'b1;
    modport dev (
        input  cs_n, sclk, sdio_lvl,
        output dev_sdio_o, dev_sdio_oe, dev_sdo_o, dev_sdo_oe
    );
    modport host (
        input  sdio_lvl, sdo_lvl,
        output cs_n, sclk, host_sdio_o, host_sdio_oe
    );
endinterface // dcsp_if

// ==== dcsp_host.sv ====
// Host end: serial master driven from a plain register port
// Assumes the register port runs on CORE_CLK_I
`timescale 1ns/1ps
module dcsp_host
    import dcsp_pkg::*;
#(
    parameter int HALF = LINK_HALF_CYC
) (
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_I,
    dcsp_if.host             LINK,
    input  wire logic [4:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    output logic             BUSY_O
);
    // ==========================================
    // Registers
    dcsp_hstate_t st;
    logic [14:0] t_addr;
    logic        rw;
    logic [1:0]  nbytes;
    logic        lsb;
    logic        w3;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [7:0]  tmr;
    logic [5:0]  bitn;
    logic [5:0]  last;
    logic [1:0]  smp_s;
    logic        tend;
    logic        go;
    logic [15:0] instr;
    logic [3:0]  ib;
    logic [5:0]  dj;
    logic [4:0]  pos;
    logic        tx_bit;
    logic        in_data;

    always_comb begin
        go = WR_I && ADDR_I == HREG_CTRL && WDATA_I[CTRL_GO] &&
             st == H_IDLE;
        tend = tmr == 8'(HALF - 1);
        last = 6'(INSTR_BITS - 1) + {1'b0, nbytes, 3'b000} +
               6'(BYTE_BITS);
        instr = {rw, t_addr};
        ib = lsb ? bitn[3:0] : ~bitn[3:0];
        dj = bitn - 6'(INSTR_BITS);
        pos = {dj[4:3], lsb ? dj[2:0] : ~dj[2:0]};
        in_data = bitn >= 6'(INSTR_BITS);
        tx_bit = in_data ? wdata[pos] : instr[ib];
    end

    // ==========================================
    // Register port
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            t_addr <= 15'h0000;
            {nbytes, rw, lsb, w3} <= 5'h00;
            wdata  <= 32'h0000_0000;
        end else if (WR_I && st == H_IDLE) begin
            if (ADDR_I == HREG_ADDR)
                t_addr <= WDATA_I[14:0];
            if (ADDR_I == HREG_CTRL) begin
                rw     <= WDATA_I[CTRL_RW];
                nbytes <= WDATA_I[CTRL_CNT +: 2];
                lsb    <= WDATA_I[CTRL_LSB];
                w3     <= WDATA_I[CTRL_3W];
            end
            if (ADDR_I == HREG_WDATA)
                wdata <= WDATA_I;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            RDATA_O <= 32'h0000_0000;
        end else if (RD_I) begin
            unique case (ADDR_I)
                HREG_ADDR:   RDATA_O <= {17'h00000, t_addr};
                HREG_CTRL:   RDATA_O <= {26'h0000000, w3, lsb,
                                         nbytes, 1'b0, rw};
                HREG_WDATA:  RDATA_O <= wdata;
                HREG_RDATA:  RDATA_O <= rdata;
                HREG_STATUS: RDATA_O <= {31'h00000000, BUSY_O};
                default:     RDATA_O <= 32'h0000_0000;
            endcase
        end else begin
            RDATA_O <= 32'h0000_0000;
        end
    end

    // ==========================================
    // Returned data sampling
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            smp_s <= 2'h3;
            rdata <= 32'h0000_0000;
        end else begin
            smp_s <= {smp_s[0], w3 ? LINK.sdio_lvl : LINK.sdo_lvl};
            if (st == H_HIGH && tend && rw && in_data)
                rdata[pos] <= smp_s[1];
        end
    end

    // ==========================================
    // Link sequencer
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            st                <= H_IDLE;
            tmr               <= 8'h00;
            bitn              <= 6'h00;
            BUSY_O            <= 1'b0;
            LINK.cs_n         <= 1'b1;
            LINK.sclk         <= 1'b0;
            LINK.host_sdio_o  <= 1'b0;
            LINK.host_sdio_oe <= 1'b0;
        end else begin
            tmr <= (st == H_IDLE || tend) ? 8'h00 : tmr + 8'h01;
            unique case (st)
                H_IDLE: if (go) begin
                    st        <= H_LEAD;
                    bitn      <= 6'h00;
                    BUSY_O    <= 1'b1;
                    LINK.cs_n <= 1'b0;
                end
                H_LEAD: if (tend) st <= H_LOW;
                H_LOW: begin
                    if (tmr == 8'h00) begin
                        LINK.host_sdio_o  <= tx_bit;
                        LINK.host_sdio_oe <= !(rw && w3 && in_data);
                    end
                    if (tend) begin
                        LINK.sclk <= 1'b1;
                        st        <= H_HIGH;
                    end
                end
                H_HIGH: if (tend) begin
                    LINK.sclk <= 1'b0;
                    if (bitn == last) begin
                        st <= H_TRAIL;
                    end else begin
                        bitn <= bitn + 6'h01;
                        st   <= H_LOW;
                    end
                end
                H_TRAIL: if (tend) begin
                    LINK.cs_n         <= 1'b1;
                    LINK.host_sdio_oe <= 1'b0;
                    st                <= H_GAP;
                end
                H_GAP: if (tend) begin
                    BUSY_O <= 1'b0;
                    st     <= H_IDLE;
                end
                default: st <= H_IDLE;
            endcase
        end
    end

endmodule // dcsp_host

// ==== dcsp_sva.sv ====
// Checker for the link between the host and device ends
// Assumes the link wires and the core clock domain, host half period 4
`timescale 1ns/1ps
module dcsp_sva (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_o,
    input wire logic dev_sdio_oe,
    input wire logic dev_sdo_o,
    input wire logic dev_sdo_oe
);
    // ==========================================
    // Link clock rises counted per frame
    logic       sclk_q;
    logic       rise;
    logic [7:0] n_rise;
    assign rise = sclk && !sclk_q;
    always_ff @(posedge CORE_CLK_I) begin
        sclk_q <= sclk;
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || cs_n) begin
            n_rise <= 8'h00;
        end else if (rise) begin
            n_rise <= n_rise + 8'h01;
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);
    sequence s_up;
        $rose(sclk);
    endsequence
    sequence s_high_half;
        sclk [*4] ##1 !sclk;
    endsequence
    // ==========================================
    // Link properties
    AST_IDLE_CLK: assert property (cs_n |-> !sclk)
        else $error("link clock moved with select high");
    AST_RELEASE: assert property (cs_n [*5] |->
        !dev_sdio_oe && !dev_sdo_oe)
        else $error("device drives with select high");
    AST_ONE_DRIVER: assert property (!(dev_sdio_oe && host_sdio_oe))
        else $error("both ends drive the shared pin");
    AST_PIN_SPLIT: assert property (!(dev_sdio_oe && dev_sdo_oe))
        else $error("device drives both data pins");
    AST_DRIVE_FALL: assert property (sclk && $past(sclk) |->
        $stable(dev_sdo_o) && $stable(dev_sdio_o))
        else $error("device data moved while clock high");
    AST_HOST_INSTR: assert property (rise && n_rise < 8'h10 |->
        host_sdio_oe)
        else $error("instruction bit not driven by host");
    AST_NO_EARLY: assert property (!cs_n && n_rise < 8'h10 |->
        !dev_sdio_oe && !dev_sdo_oe)
        else $error("device drives during instruction");
    AST_FRAME_LEN: assert property ($rose(cs_n) |->
        n_rise >= 8'h18 && n_rise[2:0] == 3'h0)
        else $error("frame is not instruction plus whole bytes");
    AST_OPEN: assert property ($fell(cs_n) |-> !sclk && !dev_sdo_oe)
        else $error("frame opened mid transfer");
    AST_HALF: assert property (s_up |-> s_high_half)
        else $error("link clock high phase wrong length");
endmodule // dcsp_sva

// ==== dcsp_bench.sv ====
// Self-checking bench: host end and device end joined by the link
// Assumes the default host half period and a 50 MHz core clock
`timescale 1ns/1ps
module dcsp_bench
    import dcsp_pkg::*;
;
    localparam logic [7:0]  CHIP  = 8'h2B; // Arbitrary value
    localparam logic [15:0] PID   = 16'hC1D7; // Arbitrary value
    localparam logic [7:0]  GR    = 8'h39; // Arbitrary value
    localparam logic [31:0] M_RD  = 32'h1 << CTRL_RW;
    localparam logic [31:0] M_LSB = 32'h1 << CTRL_LSB;
    localparam logic [31:0] M_3W  = 32'h1 << CTRL_3W;
    logic        clk;
    logic        rst;
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        busy;
    logic [7:0]  cfg;
    logic        soft_rst;
    logic        wpulse;
    int          n_errors;
    int          samples_checked;
    int          pulses = 0;
    int          late = 0;
    dcsp_if dcsp_if_i ();
    dcsp_device #(.CHIP_TYPE(CHIP), .PRODUCT_ID(PID), .GRADE(GR[7:4]),
        .REVISION(GR[3:0])) dcsp_device_i (.CORE_CLK_I(clk),
        .RESET_I(rst), .LINK(dcsp_if_i.dev), .CONFIG_O(cfg),
        .SOFT_RESET_O(soft_rst), .WRITE_PULSE_O(wpulse));
    dcsp_host dcsp_host_i (.CORE_CLK_I(clk), .RESET_I(rst),
        .LINK(dcsp_if_i.host), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .BUSY_O(busy));
    dcsp_sva dcsp_sva_i (.CORE_CLK_I(clk), .RESET_I(rst),
        .cs_n(dcsp_if_i.cs_n), .sclk(dcsp_if_i.sclk),
        .host_sdio_oe(dcsp_if_i.host_sdio_oe),
        .dev_sdio_o(dcsp_if_i.dev_sdio_o),
        .dev_sdio_oe(dcsp_if_i.dev_sdio_oe),
        .dev_sdo_o(dcsp_if_i.dev_sdo_o), .dev_sdo_oe(dcsp_if_i.dev_sdo_oe));
    // ==========================================
    // Clock and write pulse monitor
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (wpulse === 1'b1) begin
            pulses <= pulses + 1;
            if (dcsp_if_i.cs_n !== 1'b0) begin
                late <= late + 1;
            end
        end
    end
    // ==========================================
    // Shared tasks
    task automatic wrap_up();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus_wr(logic [4:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic xfer(logic [14:0] a, logic [31:0] mode, int nb,
                        logic [31:0] wd, output logic [31:0] v);
        int k;
        bus_wr(HREG_ADDR, {17'h0, a});
        bus_wr(HREG_WDATA, wd);
        bus_wr(HREG_CTRL, mode | ((nb - 1) << CTRL_CNT) | (1 << CTRL_GO));
        k = 0;
        #1;
        while (k < 1000 && busy !== 1'b0) begin
            @(posedge clk);
            #1 k++;
        end
        if (k >= 1000) begin
            n_errors++;
            $display("[ERR] busy expected 0 seen 1");
        end
        bus_rd(HREG_RDATA, v);
        v = (v << (32 - 8 * nb)) >> (32 - 8 * nb);
    endtask
    // ==========================================
    // Scenarios
    task automatic s_reset();
        logic [31:0] v;
        chk("config", 32'h0, {24'h0, cfg});
        bus_rd(HREG_STATUS, v);
        chk("status", 32'h0, v);
        bus_rd(5'h14, v);
        chk("unmapped", 32'h0, v);
    endtask
    task automatic s_id_down();
        logic [31:0] v;
        xfer(OFF_GRADE, M_RD | M_3W, 4, 32'h0, v);
        chk("id down", {CHIP, PID[7:0], PID[15:8], GR}, v);
    endtask
    task automatic s_soft_reset();
        logic [31:0] v;
        int          p;
        p = pulses;
        xfer(OFF_CFG, M_3W, 1, {24'h0, SOFT_RST_PAT}, v);
        chk("cfg in reset", 32'h81, {24'h0, cfg});
        chk("soft reset", 32'h1, {31'h0, soft_rst});
        xfer(OFF_CFG, M_3W, 1, {24'h0, CFG_RELEASE}, v);
        chk("cfg released", 32'h3C, {24'h0, cfg});
        chk("soft reset", 32'h0, {31'h0, soft_rst});
        chk("write pulses", 32'(p + 2), 32'(pulses));
        chk("late pulses", 32'h0, 32'(late));
        xfer(OFF_CFG, M_RD, 1, 32'h0, v);
        chk("cfg read", 32'h3C, v);
    endtask
    task automatic s_id_up();
        logic [31:0] v;
        int          p;
        p = pulses;
        xfer(OFF_CHIP, M_RD, 4, 32'h0, v);
        chk("id up", {GR, PID[15:8], PID[7:0], CHIP}, v);
        chk("read pulses", 32'(p), 32'(pulses));
    endtask
    task automatic s_ro_write();
        logic [31:0] v;
        int          p;
        p = pulses;
        xfer(OFF_CHIP, 32'h0, 3, 32'h00C3A5, v);
        chk("ro pulses", 32'(p + 3), 32'(pulses));
        xfer(OFF_PID_LO, M_RD, 2, 32'h0, v);
        chk("ro kept", {16'h0, PID}, v);
    endtask
    task automatic s_lsb();
        logic [31:0] v;
        xfer(OFF_CFG, 32'h0, 1, 32'h70, v);
        chk("cfg nibble", 32'h7E, {24'h0, cfg});
        xfer(OFF_PID_HI, M_RD | M_LSB, 2, 32'h0, v);
        chk("lsb read", {16'h0, GR, PID[15:8]}, v);
        xfer(OFF_CFG, M_LSB, 1, 32'h0C, v);
        chk("cfg back", 32'h3C, {24'h0, cfg});
        xfer(OFF_CHIP, M_RD, 1, 32'h0000_00A5, v);
        chk("msb read", {24'h0, CHIP}, v);
        bus_rd(HREG_ADDR, v);
        chk("addr back", {17'h0, OFF_CHIP}, v);
        bus_rd(HREG_CTRL, v);
        chk("ctrl back", M_RD, v);
        bus_rd(HREG_WDATA, v);
        chk("wdata back", 32'h0000_00A5, v);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        addr = 5'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        s_reset();
        s_id_down();
        s_soft_reset();
        s_id_up();
        s_ro_write();
        s_lsb();
        wrap_up();
    end
endmodule // dcsp_bench
